// [hw/dew_pkg.sv]
// Shared constants and types for the data EEPROM write controller.
// Assumes a single 250 MHz core clock and an APB register port.
package dew_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned POWERUP_TIME_MS = 64;
  localparam int unsigned ERASE_TIME_US   = 2;
  localparam int unsigned PROG_TIME_US    = 2;
  // Least times round up to whole clock cycles.
  localparam int unsigned POWERUP_CYCLES  =
    (POWERUP_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYCLES    =
    (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYCLES     =
    (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UNLOCK_WINDOW_CYCLES = 16;

  // --------------------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------------------
  localparam int unsigned APB_ADDR_W = 8;
  localparam logic [7:0] OFS_BYTE_DATA  = 8'h00;
  localparam logic [7:0] OFS_BYTE_ADDR  = 8'h04;
  localparam logic [7:0] OFS_NV_CONTROL = 8'h08;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_STATE      = 8'h1C;

  localparam int unsigned CTRL_READ_BIT   = 0;
  localparam int unsigned CTRL_START_BIT  = 1;
  localparam int unsigned CTRL_PERMIT_BIT = 2;
  localparam int unsigned CTRL_ABORT_BIT  = 3;

  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_ABORT_BIT  = 1;
  localparam int unsigned IRQ_REFUSE_BIT = 2;

  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // --------------------------------------------------------------------------
  // State types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEY1, SEQ_ARMED} dew_seq_type;
  typedef enum logic [1:0] {WR_IDLE, WR_ERASE, WR_PROG} dew_wr_type;

endpackage : dew_pkg

// [hw/dew_array_if.sv]
// Port bundle between the write controller and its byte array.
// Assumes both ends run on the same core clock.
interface dew_array_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : dew_array_if

// [hw/dew_nv_array.sv]
// Byte array with one write port and one registered read port.
// Assumes the controller holds one write strobe per erase or program step.
module dew_nv_array #(
  parameter int DEPTH = 256
) (
  // Clock.
  input  wire logic mclk_i,
  // Array port.
  dew_array_if.mem  arr
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] mem_reg [DEPTH];

  initial begin
    if (DEPTH != (1 << $bits(arr.waddr))) begin
      $error("DEPTH must match the address width");
    end
  end

  // Write and registered read.
  always_ff @(posedge mclk_i) begin
    if (arr.we) begin
      mem_reg[arr.waddr] <= arr.wdata;
    end
    arr.rdata <= mem_reg[arr.raddr];
  end

endmodule : dew_nv_array

// [hw/dew_self_timer.sv]
// Down counter that times one erase or program step.
// Assumes start and abort come from logic on the same clock.
module dew_self_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  // Control.
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] cycles_i,
  input  wire logic             abort_i,
  // Status.
  output logic                  done_o
);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg;
  logic             run_reg;

  initial begin
    if (CNT_W < 2) begin
      $error("CNT_W too small");
    end
  end

  // Done pulses one cycle after the count reaches one.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= run_reg && !abort_i && (cnt_reg == CNT_W'(1));
      if (abort_i) begin
        run_reg <= 1'b0;
      end else if (start_i) begin
        cnt_reg <= cycles_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
        run_reg <= (cnt_reg != CNT_W'(1));
      end
    end
  end

endmodule : dew_self_timer

// [hw/dew_write_ctrl.sv]
// Data EEPROM write controller: APB registers, unlock sequence, timed
// erase-then-program, power-up lockout, abort on warm resets, interrupt.
// Assumes an APB master on mclk_i; warm reset inputs and the fuse are pins.
//
// Functional notes
// [RULE_01] Software loads address and data registers before starting a write.
// [RULE_02] Start needs key 55h, then AAh, then start bit, in that order.
// [RULE_03] Each sequence step must come within the timing window, else void.
// [RULE_04] Software should mask interrupts across the unlock sequence.
// [RULE_05] Start bit cannot set unless write permit is already set.
// [RULE_06] Hardware never clears the write permit bit by itself.
// [RULE_07] Clearing permit during a write does not stop that write.
// [RULE_08] At the end, start bit clears and completion flag sets.
// [RULE_09] Software clears the completion flag; hardware never does.
// [RULE_10] Software should keep permit clear except while updating.
// [RULE_11] Permit resets clear; no write while power-up timer runs.
// [RULE_12] Data protect fuse leaves internal reads and writes unaffected.
// [RULE_13] Array has 256 bytes addressed by the full 8-bit address.
// [RULE_14] Warm reset during a write sets the write abort flag.
// [RULE_15] Unlock key register stores nothing and reads as zero.
// [RULE_16] Each byte write erases then programs, each self-timed.
// [RULE_17] Any other bus access cancels unlock tracking.
// [RULE_18] Starts are ignored while busy; latched address and data hold.
module dew_write_ctrl
  import dew_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES_P = POWERUP_CYCLES,
  parameter int unsigned ERASE_CYCLES_P   = ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES_P    = PROG_CYCLES,
  parameter int unsigned UNLOCK_WINDOW_P  = UNLOCK_WINDOW_CYCLES
) (
  // Clock and reset.
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  // APB slave.
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [APB_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Warm reset sources and configuration fuse.
  input  wire logic                  external_reset_pin_i,
  input  wire logic                  wdt_reset_i,
  input  wire logic                  bor_reset_i,
  input  wire logic                  data_protect_fuse_i,
  // Interrupt.
  output logic                       irq_o
);

  // --------------------------------------------------------------------------
  // Parameter checks and widths
  // --------------------------------------------------------------------------
  localparam int TMR_W = $clog2((ERASE_CYCLES_P > PROG_CYCLES_P ?
                                 ERASE_CYCLES_P : PROG_CYCLES_P) + 1) + 1;
  localparam int PU_W  = $clog2(POWERUP_CYCLES_P + 1) + 1;
  localparam int WIN_W = $clog2(UNLOCK_WINDOW_P + 1) + 1;

  initial begin
    if (ERASE_CYCLES_P < 1 || PROG_CYCLES_P < 1 || POWERUP_CYCLES_P < 1 ||
        UNLOCK_WINDOW_P < 2) begin
      $error("Timing parameters out of range");
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  // Two flops per pin; only the second stage is used.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {data_protect_fuse_i, bor_reset_i, wdt_reset_i,
                       external_reset_pin_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic warm_rst;
  logic fuse_q;
  assign warm_rst = |pin_sync_reg[2:0];
  assign fuse_q   = pin_sync_reg[3];

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic       pready_reg;
  logic       xfer;
  logic       wr_xfer;
  logic       rd_phase;
  logic       hit_data, hit_addr, hit_ctrl, hit_key;
  logic       hit_stat, hit_clr, hit_en, hit_state, mapped;
  logic [7:0] wbyte;

  // A transfer completes when the slave has raised pready.
  assign xfer      = psel_i && penable_i && pready_reg;
  assign wr_xfer   = xfer && pwrite_i;
  assign rd_phase  = psel_i && penable_i && !pready_reg;
  assign wbyte     = pwdata_i[7:0];
  assign hit_data  = (paddr_i == OFS_BYTE_DATA);
  assign hit_addr  = (paddr_i == OFS_BYTE_ADDR);
  assign hit_ctrl  = (paddr_i == OFS_NV_CONTROL);
  assign hit_key   = (paddr_i == OFS_UNLOCK_KEY);
  assign hit_stat  = (paddr_i == OFS_IRQ_STATUS);
  assign hit_clr   = (paddr_i == OFS_IRQ_CLEAR);
  assign hit_en    = (paddr_i == OFS_IRQ_ENABLE);
  assign hit_state = (paddr_i == OFS_STATE);
  assign mapped    = hit_data | hit_addr | hit_ctrl | hit_key |
                     hit_stat | hit_clr | hit_en | hit_state;

  // --------------------------------------------------------------------------
  // State declarations
  // --------------------------------------------------------------------------
  dew_seq_type        seq_reg, seq_next;
  dew_wr_type         wr_reg, wr_next;
  logic [7:0]         data_reg, addr_reg, lat_data_reg, lat_addr_reg;
  logic               permit_reg, start_reg, abort_reg, rd_pend_reg;
  logic [WIN_W-1:0]   gap_reg;
  logic [PU_W-1:0]    pu_cnt_reg;
  logic               pu_done_reg;
  logic [IRQ_W-1:0]   stat_reg, stat_next, en_reg, set_mask, clr_mask;
  logic               tmr_done;
  logic               ctrl_wr, start_try, start_ok, refused, busy, gap_ok;
  logic               erase_end, prog_end, warm_abort;

  dew_array_if #(.AW(8), .DW(8)) arr ();

  // --------------------------------------------------------------------------
  // Unlock sequence tracking
  // --------------------------------------------------------------------------
  assign ctrl_wr   = wr_xfer && hit_ctrl;
  assign gap_ok    = (gap_reg < WIN_W'(UNLOCK_WINDOW_P));
  assign busy      = (wr_reg != WR_IDLE);
  // [RULE_02] Start only right after both keys.
  assign start_try = ctrl_wr && wbyte[CTRL_START_BIT] && (seq_reg == SEQ_ARMED) && gap_ok;
  // [RULE_05] Permit gates start.
  // [RULE_11] Power-up lockout.
  // [RULE_18] Ignored while busy.
  assign start_ok  = start_try && permit_reg && pu_done_reg && !busy && !warm_rst;
  assign refused   = ctrl_wr && wbyte[CTRL_START_BIT] && !busy && !start_ok;

  // [RULE_02] Key order 55h then AAh.
  // [RULE_03] Window on each step.
  // [RULE_17] Other access cancels.
  always_comb begin
    seq_next = seq_reg;
    if (warm_rst || (seq_reg != SEQ_IDLE && !gap_ok)) begin
      seq_next = SEQ_IDLE;
    end else if (xfer) begin
      if (wr_xfer && hit_key && wbyte == KEY_FIRST) begin
        seq_next = SEQ_KEY1;
      end else if (wr_xfer && hit_key && wbyte == KEY_SECOND && seq_reg == SEQ_KEY1) begin
        seq_next = SEQ_ARMED;
      end else begin
        seq_next = SEQ_IDLE;
      end
    end
  end

  // Sequence state and step gap counter.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_reg <= SEQ_IDLE;
      gap_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      if (xfer) begin
        gap_reg <= '0;
      end else if (gap_ok) begin
        gap_reg <= gap_reg + WIN_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power-up timer
  // --------------------------------------------------------------------------
  // [RULE_11] Count out the power-up time.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pu_cnt_reg  <= '0;
      pu_done_reg <= 1'b0;
    end else if (!pu_done_reg) begin
      pu_cnt_reg  <= pu_cnt_reg + PU_W'(1);
      pu_done_reg <= (pu_cnt_reg == PU_W'(POWERUP_CYCLES_P - 1));
    end
  end

  // --------------------------------------------------------------------------
  // Erase and program sequencer
  // --------------------------------------------------------------------------
  assign erase_end  = (wr_reg == WR_ERASE) && tmr_done;
  assign prog_end   = (wr_reg == WR_PROG) && tmr_done;
  assign warm_abort = warm_rst && busy;

  // [RULE_16] Erase then program.
  // [RULE_07] Permit is not looked at once running.
  always_comb begin
    wr_next = wr_reg;
    case (wr_reg)
      WR_IDLE:  if (start_ok) wr_next = WR_ERASE;
      WR_ERASE: if (warm_rst) wr_next = WR_IDLE; else if (tmr_done) wr_next = WR_PROG;
      WR_PROG:  if (warm_rst || tmr_done) wr_next = WR_IDLE;
      default:  wr_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_reg <= WR_IDLE;
    end else begin
      wr_reg <= wr_next;
    end
  end

  // [RULE_18] Latch address and data at start.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat_addr_reg <= RESET_BYTE;
      lat_data_reg <= RESET_BYTE;
    end else if (start_ok) begin
      lat_addr_reg <= addr_reg;
      lat_data_reg <= data_reg;
    end
  end

  // [RULE_16] Self-timed steps.
  dew_self_timer #(.CNT_W(TMR_W)) u_timer (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (start_ok || erase_end),
    .cycles_i (start_ok ? TMR_W'(ERASE_CYCLES_P) : TMR_W'(PROG_CYCLES_P)),
    .abort_i  (warm_rst),
    .done_o   (tmr_done)
  );

  // [RULE_13] Full 8-bit address, 256 bytes.
  // [RULE_12] Fuse does not gate internal access.
  assign arr.we    = start_ok || (erase_end && !warm_rst);
  assign arr.waddr = start_ok ? addr_reg : lat_addr_reg;
  assign arr.wdata = start_ok ? ERASED_BYTE : lat_data_reg;
  assign arr.raddr = addr_reg;

  dew_nv_array #(.DEPTH(256)) u_array (
    .mclk_i (mclk_i),
    .arr    (arr)
  );

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  // Data, address and the read strobe; warm resets clear them.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_reg    <= RESET_BYTE;
      addr_reg    <= RESET_BYTE;
      rd_pend_reg <= 1'b0;
    end else if (warm_rst) begin
      data_reg    <= RESET_BYTE;
      addr_reg    <= RESET_BYTE;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= ctrl_wr && wbyte[CTRL_READ_BIT];
      if (rd_pend_reg) begin
        data_reg <= arr.rdata;
      end else if (wr_xfer && hit_data) begin
        data_reg <= wbyte;
      end
      if (wr_xfer && hit_addr) begin
        addr_reg <= wbyte;
      end
    end
  end

  // Control bits: permit, start and abort flag.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // [RULE_11] Permit comes up clear.
      permit_reg <= 1'b0;
      start_reg  <= 1'b0;
      abort_reg  <= 1'b0;
    end else begin
      // [RULE_06] Only software or a reset changes permit.
      if (warm_rst) begin
        permit_reg <= 1'b0;
      end else if (ctrl_wr) begin
        permit_reg <= wbyte[CTRL_PERMIT_BIT];
      end
      // [RULE_08] Start clears at the end of the write.
      if (start_ok) begin
        start_reg <= 1'b1;
      end else if (prog_end || warm_abort) begin
        start_reg <= 1'b0;
      end
      // [RULE_14] Warm reset mid-write sets abort; the set wins.
      if (warm_abort) begin
        abort_reg <= 1'b1;
      end else if (ctrl_wr) begin
        abort_reg <= wbyte[CTRL_ABORT_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, clear and enable
  // --------------------------------------------------------------------------
  // [RULE_08] Completion sets its flag.
  assign set_mask = {refused, warm_abort, prog_end && !warm_rst};
  // [RULE_09] Only software clears; a new event wins.
  assign clr_mask = (wr_xfer && hit_clr) ? pwdata_i[IRQ_W-1:0] : '0;
  assign stat_next = (stat_reg & ~clr_mask) | set_mask;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_reg <= '0;
      en_reg   <= '0;
      irq_o    <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_xfer && hit_en) begin
        en_reg <= pwdata_i[IRQ_W-1:0];
      end
      irq_o <= |(stat_reg & en_reg);
    end
  end

  // --------------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;

  // [RULE_15] Unlock key reads as zero.
  assign rd_mux =
    hit_data  ? {24'h0, data_reg} :
    hit_addr  ? {24'h0, addr_reg} :
    hit_ctrl  ? {28'h0, abort_reg, permit_reg, start_reg, rd_pend_reg} :
    hit_stat  ? {29'h0, stat_reg} :
    hit_en    ? {29'h0, en_reg} :
    hit_state ? {28'h0, seq_reg == SEQ_ARMED, fuse_q, pu_done_reg, busy} :
    32'h00000000;

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= 32'h00000000;
    end else begin
      pready_reg <= rd_phase;
      pslverr_o  <= rd_phase && !mapped;
      if (rd_phase && !pwrite_i) begin
        prdata_o <= rd_mux;
      end
    end
  end

  assign pready_o = pready_reg;

endmodule : dew_write_ctrl

// [dv/dew_write_ctrl_properties.sv]
// Concurrent checks on the write controller's APB port and interrupt pin.
// Assumes a bind onto dew_write_ctrl; sees only the ports it checks.
module dew_write_ctrl_properties
  import dew_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  resetn_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [APB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic                  irq_o
);
  // --------
  // Helpers
  // --------
  // Taken write to the irq clear or enable register.
  wire irq_wr = psel_i && penable_i && pready_o && pwrite_i &&
                (paddr_i == OFS_IRQ_CLEAR || paddr_i == OFS_IRQ_ENABLE);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // --------
  // Properties
  // --------
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_one_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
  property p_ready_in_access;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  property p_err_with_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_unmapped_err;
    pready_o && paddr_i > OFS_STATE |-> pslverr_o;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");
  property p_mapped_ok;
    pready_o && paddr_i <= OFS_STATE && paddr_i[1:0] == 2'h0 |-> !pslverr_o;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged");
  property p_err_read_zero;
    pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
  endproperty
  a_err_read_zero: assert property (p_err_read_zero) else $error("unmapped read not zero");
  property p_key_reads_zero;
    pready_o && !pwrite_i && paddr_i == OFS_UNLOCK_KEY |-> prdata_o == 32'h0;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read not zero");
  property p_upper_zero;
    pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_irq_sticky;
    irq_o && !irq_wr && !$past(irq_wr) |=> irq_o;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped by itself");
endmodule : dew_write_ctrl_properties

bind dew_write_ctrl dew_write_ctrl_properties u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_o(irq_o)
);

// [dv/dew_write_ctrl_tb.sv]
// Self-checking bench for the data EEPROM write controller over APB.
// Assumes short power-up and timer counts at the instance.
module dew_write_ctrl_tb
  import dew_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // --------
  // Signals
  // --------
  logic        mclk_i    = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [2:0]  warm_rst  = 3'h0;
  logic        fuse      = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic [31:0] rdata;
  logic        rerr;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;
  logic [7:0]  bad1 [5] = '{8'hAA, 8'h55, 8'h55, 8'h55, 8'h55};
  logic [7:0]  bad2 [5] = '{8'h55, 8'h55, 8'h00, 8'hAA, 8'hAA};

  dew_write_ctrl #(.POWERUP_CYCLES_P(50), .ERASE_CYCLES_P(25), .PROG_CYCLES_P(25),
    .UNLOCK_WINDOW_P(16)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .external_reset_pin_i(warm_rst[0]),
    .wdt_reset_i(warm_rst[1]), .bor_reset_i(warm_rst[2]),
    .data_protect_fuse_i(fuse), .irq_o(irq_o));

  // Clock and hang guard.
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      summarize();
    end
  end

  // --------
  // Tasks
  // --------
  // One APB transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: pin got %b exp %b", $time, got, exp);
    end
  endtask : chk_pin
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, exp);
  endtask : rd_chk
  // Keys and start back to back.
  task automatic start_wr(input logic [7:0] k1, input logic [7:0] k2, input logic [31:0] c);
    wr(OFS_UNLOCK_KEY, {24'h0, k1});
    wr(OFS_UNLOCK_KEY, {24'h0, k2});
    wr(OFS_NV_CONTROL, c);
  endtask : start_wr
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq_o !== 1'b1; i++) @(posedge mclk_i);
    chk_pin(irq_o, 1'b1);
  endtask : wait_irq
  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // --------
  // Tests
  // --------
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd_chk(OFS_BYTE_DATA, 32'h0, 32'hFF);
    rd_chk(OFS_BYTE_ADDR, 32'h0, 32'hFF);
    rd_chk(OFS_NV_CONTROL, 32'h0, 32'hF);
    rd_chk(OFS_UNLOCK_KEY, 32'h0, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0, 32'hFFFFFFFF);
    chk_pin(rerr, 1'b1);
    wr(OFS_NV_CONTROL, 32'h4);
    start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
    rd_chk(OFS_STATE, 32'h0, 32'h3);
    repeat (20) @(posedge mclk_i);
    rd_chk(OFS_STATE, 32'h2, 32'h3);
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h1);
    $display("test power-up done");
    wr(OFS_NV_CONTROL, 32'h0);
    start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
    rd_chk(OFS_IRQ_STATUS, 32'h4, 32'h7);
    rd_chk(OFS_NV_CONTROL, 32'h4, 32'hF);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_IRQ_CLEAR, 32'h7);
      wr(OFS_UNLOCK_KEY, {24'h0, bad1[i]});
      if (i == 3) apb(1'b0, OFS_BYTE_DATA, 32'h0);
      if (i == 4) repeat (20) @(posedge mclk_i);
      wr(OFS_UNLOCK_KEY, {24'h0, bad2[i]});
      wr(OFS_NV_CONTROL, 32'h6);
      rd_chk(OFS_IRQ_STATUS, 32'h4, 32'h7);
    end
    wr(OFS_IRQ_CLEAR, 32'h7);
    $display("test refusals done");
    wr(OFS_BYTE_ADDR, 32'hFF);
    wr(OFS_BYTE_DATA, 32'hA5);
    start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
    rd_chk(OFS_NV_CONTROL, 32'h6, 32'hF);
    rd_chk(OFS_STATE, 32'h1, 32'h1);
    wr(OFS_BYTE_DATA, 32'h11);
    wr(OFS_BYTE_ADDR, 32'h22);
    start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
    wr(OFS_NV_CONTROL, 32'h0);
    wait_irq();
    rd_chk(OFS_IRQ_STATUS, 32'h1, 32'h7);
    rd_chk(OFS_NV_CONTROL, 32'h0, 32'hF);
    wr(OFS_BYTE_ADDR, 32'hFF);
    wr(OFS_NV_CONTROL, 32'h1);
    rd_chk(OFS_BYTE_DATA, 32'hA5, 32'hFF);
    wr(OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk_pin(irq_o, 1'b0);
    wr(OFS_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk_pin(irq_o, 1'b1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk_pin(irq_o, 1'b0);
    $display("test write done");
    fuse <= 1'b1;
    wr(OFS_BYTE_ADDR, 32'h00);
    wr(OFS_BYTE_DATA, 32'h3C);
    wr(OFS_NV_CONTROL, 32'h4);
    start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
    wait_irq();
    rd_chk(OFS_NV_CONTROL, 32'h4, 32'hF);
    rd_chk(OFS_STATE, 32'h4, 32'h5);
    wr(OFS_NV_CONTROL, 32'h5);
    rd_chk(OFS_BYTE_DATA, 32'h3C, 32'hFF);
    wr(OFS_IRQ_CLEAR, 32'h7);
    $display("test fuse write done");
    for (int i = 0; i < 3; i++) begin
      wr(OFS_BYTE_DATA, 32'h5A);
      wr(OFS_NV_CONTROL, 32'h4);
      start_wr(KEY_FIRST, KEY_SECOND, 32'h6);
      warm_rst[i] <= 1'b1;
      @(posedge mclk_i);
      warm_rst[i] <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rd_chk(OFS_NV_CONTROL, 32'h8, 32'hF);
      rd_chk(OFS_IRQ_STATUS, 32'h2, 32'h7);
      rd_chk(OFS_BYTE_DATA, 32'h0, 32'hFF);
      wr(OFS_NV_CONTROL, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h7);
    end
    $display("test warm abort done");
    summarize();
  end
endmodule : dew_write_ctrl_tb
